// *** tap_pulse_cfg.svh ***
// Offsets, reset values, scaling and step timing constants for the tap qualifier
`ifndef TAP_PULSE_CFG_SVH
`define TAP_PULSE_CFG_SVH

`define ADDR_TAP_THRESHOLD_Y 8'h24
`define ADDR_TAP_THRESHOLD_Z 8'h25
`define ADDR_TAP_TIME_LIMIT  8'h26

`define THRESHOLD_RESET      7'h00
`define TIME_LIMIT_RESET     8'h00
`define READ_UNMAPPED        8'h00

// 12-bit samples on the fixed 8 g scale; one threshold count is 16 sample counts
`define THRESHOLD_LSB_SHIFT  4

`define CLOCK_PERIOD_NS      100
// Shortest time step, 0.625 ms
`define BASE_STEP_US         625
`define BASE_STEP_CYCLES     ((`BASE_STEP_US * 1000) / `CLOCK_PERIOD_NS)

// Step exponents over the base step; nibble n belongs to data-rate code n
`define STEP_EXP_LPF1_NORMAL 32'h5555_4321
`define STEP_EXP_LPF1_LOWNSE 32'h7775_4321
`define STEP_EXP_LPF1_HIRES  32'h2222_2221
`define STEP_EXP_LPF1_LOWPWR 32'h8875_4321
`define STEP_EXP_LPF0_NORMAL 32'h3333_2100
`define STEP_EXP_LPF0_LOWNSE 32'h5553_2100
`define STEP_EXP_LPF0_HIRES  32'h0000_0000
`define STEP_EXP_LPF0_LOWPWR 32'h6664_3210

`endif

// *** tap_pulse_pkg.sv ***
// Types shared by the tap qualifier modules
package tap_pulse_pkg;

  typedef enum logic [1:0] {
    NORMAL_OVERSAMPLING              = 2'b00,
    LOW_NOISE_LOW_POWER_OVERSAMPLING = 2'b01,
    HIGH_RESOLUTION_OVERSAMPLING     = 2'b10,
    LOW_POWER_OVERSAMPLING           = 2'b11
  } oversampling_e;

  typedef enum logic [1:0] {
    TAP_IDLE     = 2'b00,
    TAP_ABOVE    = 2'b01,
    TAP_WAIT_LOW = 2'b10
  } tap_state_e;

  typedef logic [2:0] data_rate_t;

endpackage

// *** tap_step_if.sv ***
// Carrier between an axis qualifier and its step timer
`timescale 1ns/1ns
interface tap_step_if;
  logic       restart;
  logic [3:0] exponent;
  logic       stepPulse;

  modport timer (
    input  restart,
    input  exponent,
    output stepPulse
  );
  modport user (
    output restart,
    output exponent,
    input  stepPulse
  );
endinterface

// *** tap_step_timer.sv ***
// Time-step enable generator: base step times a power of two
`timescale 1ns/1ns
`include "tap_pulse_cfg.svh"
module tap_step_timer
  import tap_pulse_pkg::*;
#(
  parameter int BASE_STEP_CYCLES = `BASE_STEP_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  tap_step_if.timer step
);
  localparam int BaseWidth = (BASE_STEP_CYCLES > 1) ? $clog2(BASE_STEP_CYCLES) : 1;

  logic [BaseWidth-1:0] baseCount_reg;
  logic [7:0]           prescale_reg;
  logic                 stepPulse_reg;
  logic                 baseWrap;
  logic [7:0]           prescaleTop;

  assign baseWrap    = baseCount_reg == BaseWidth'(BASE_STEP_CYCLES - 1);
  assign prescaleTop = 8'((9'd1 << step.exponent) - 9'd1);
  assign step.stepPulse = stepPulse_reg;

  // Restart aligns the first step to the start of a candidate, not to a free-running grid
  always_ff @(posedge clk) begin
    if (reset || step.restart || baseWrap) begin
      baseCount_reg <= '0;
    end else begin
      baseCount_reg <= baseCount_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || step.restart) begin
      prescale_reg <= 8'h00;
    end else if (baseWrap) begin
      prescale_reg <= (prescale_reg >= prescaleTop) ? 8'h00 : prescale_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || step.restart) begin
      stepPulse_reg <= 1'b0;
    end else begin
      stepPulse_reg <= baseWrap && (prescale_reg >= prescaleTop);
    end
  end

  logic [31:0] gap_reg;
  always_ff @(posedge clk) begin
    if (reset || step.restart) begin
      gap_reg <= 32'h0000_0000;
    end else if (step.stepPulse) begin
      gap_reg <= 32'h0000_0001;
    end else begin
      gap_reg <= gap_reg + 32'h0000_0001;
    end
  end

  stepPeriod_a: assert property (@(posedge clk) disable iff (reset)
    step.stepPulse |-> gap_reg == (32'(BASE_STEP_CYCLES) << step.exponent))
    else $error("time step period does not match the selected step size");

  longStep_c: cover property (@(posedge clk) disable iff (reset)
    step.stepPulse && step.exponent == 4'h8);
endmodule

// *** pulse_threshold_time_limit.sv ***
// Tap threshold and time-limit registers with per-axis tap qualification
`timescale 1ns/1ns
`include "tap_pulse_cfg.svh"
// Behaviour
// - Y threshold seven bits, bit7 zero, reset zero
// - Z threshold seven bits, bit7 zero, reset zero
// - Compare on fixed 8 g scale, 0.063 g
// - Threshold is seven-bit unsigned magnitude
// - Candidate starts when acceleration exceeds threshold
// - Time limit eight bits, read/write, reset zero
// - Valid only if falling below within limit
// - Longest limit is 255 time steps
// - Step depends on oversampling and lowpass enable
// - Lowpass enable comes from filter register
// - Filtered steps from 1.25 ms upward
// - Unfiltered steps are a half or a quarter of filtered, from 0.625 ms
// - Each limit count is one time step
module pulse_threshold_time_limit
  import tap_pulse_pkg::*;
#(
  parameter int BASE_STEP_CYCLES = `BASE_STEP_CYCLES
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic [7:0]    regAddr,
  input  wire logic [7:0]    regWrData,
  input  wire logic          regWrite,
  input  wire logic          regRead,
  output logic      [7:0]    regRdData,
  input  wire logic          sampleValid,
  input  wire logic [11:0]   accelY,
  input  wire logic [11:0]   accelZ,
  input  wire data_rate_t    outputDataRate,
  input  wire oversampling_e oversamplingMode,
  input  wire logic          tapLowpassEnable,
  output logic      [1:0]    tapValid,
  output logic      [1:0]    tapNegative,
  output logic      [1:0]    tapExpired
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  logic [6:0] yThresholdField_reg;
  logic [6:0] zThresholdField_reg;
  logic [7:0] timeLimitField_reg;
  logic [7:0] regRdData_reg;
  logic [3:0] exponent;

  function automatic logic [3:0] stepExponent(
    input logic          lowpass,
    input oversampling_e mode,
    input data_rate_t    rate
  );
    logic [31:0] row;
    row = 32'h0000_0000;
    if (lowpass) begin
      case (mode)
        NORMAL_OVERSAMPLING:              row = `STEP_EXP_LPF1_NORMAL;
        LOW_NOISE_LOW_POWER_OVERSAMPLING: row = `STEP_EXP_LPF1_LOWNSE;
        HIGH_RESOLUTION_OVERSAMPLING:     row = `STEP_EXP_LPF1_HIRES;
        LOW_POWER_OVERSAMPLING:           row = `STEP_EXP_LPF1_LOWPWR;
        default:                          row = 32'h0000_0000;
      endcase
    end else begin
      case (mode)
        NORMAL_OVERSAMPLING:              row = `STEP_EXP_LPF0_NORMAL;
        LOW_NOISE_LOW_POWER_OVERSAMPLING: row = `STEP_EXP_LPF0_LOWNSE;
        HIGH_RESOLUTION_OVERSAMPLING:     row = `STEP_EXP_LPF0_HIRES;
        LOW_POWER_OVERSAMPLING:           row = `STEP_EXP_LPF0_LOWPWR;
        default:                          row = 32'h0000_0000;
      endcase
    end
    return row[{rate, 2'b00} +: 4];
  endfunction

  // Lowpass enable arrives live from the filter configuration register
  assign exponent = stepExponent(tapLowpassEnable, oversamplingMode,
                                 outputDataRate);

  always_ff @(posedge clk) begin
    if (reset) begin
      yThresholdField_reg <= `THRESHOLD_RESET;
      zThresholdField_reg <= `THRESHOLD_RESET;
      timeLimitField_reg  <= `TIME_LIMIT_RESET;
    end else if (regWrite) begin
      case (regAddr)
        `ADDR_TAP_THRESHOLD_Y: yThresholdField_reg <= regWrData[6:0];
        `ADDR_TAP_THRESHOLD_Z: zThresholdField_reg <= regWrData[6:0];
        `ADDR_TAP_TIME_LIMIT:  timeLimitField_reg  <= regWrData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      regRdData_reg <= `READ_UNMAPPED;
    end else if (regRead) begin
      case (regAddr)
        `ADDR_TAP_THRESHOLD_Y: regRdData_reg <= {1'b0, yThresholdField_reg};
        `ADDR_TAP_THRESHOLD_Z: regRdData_reg <= {1'b0, zThresholdField_reg};
        `ADDR_TAP_TIME_LIMIT:  regRdData_reg <= timeLimitField_reg;
        default:               regRdData_reg <= `READ_UNMAPPED;
      endcase
    end
  end
  assign regRdData = regRdData_reg;

  logic [11:0] accel [2];
  logic [6:0]  threshold [2];
  assign accel[0]     = accelY;
  assign accel[1]     = accelZ;
  assign threshold[0] = yThresholdField_reg;
  assign threshold[1] = zThresholdField_reg;

  tap_step_if stepBus [2] ();

  genvar axis;
  generate
    for (axis = 0; axis < 2; axis++) begin : gAxis
      tap_state_e  state_reg;
      logic [7:0]  count_reg;
      logic        valid_reg;
      logic        negative_reg;
      logic        expired_reg;
      logic [11:0] magnitude;
      logic        above;
      logic        limitHit;

      // Input is already on the 8 g scale, so the output full-scale setting never matters
      assign magnitude = accel[axis][11] ? 12'(-accel[axis]) : accel[axis];
      assign above     = magnitude[11:`THRESHOLD_LSB_SHIFT] > {1'b0, threshold[axis]};
      assign limitHit  = count_reg >= timeLimitField_reg;

      assign stepBus[axis].restart  = state_reg != TAP_ABOVE;
      assign stepBus[axis].exponent = exponent;

      tap_step_timer #(
        .BASE_STEP_CYCLES (BASE_STEP_CYCLES)
      ) uTimer (
        .clk   (clk),
        .reset (reset),
        .step  (stepBus[axis])
      );

      // Expiry wins over a fall in the same cycle: the fall was not within the limit
      always_ff @(posedge clk) begin
        if (reset) begin
          state_reg <= TAP_IDLE;
        end else begin
          case (state_reg)
            TAP_IDLE: begin
              if (sampleValid && above) begin
                state_reg <= TAP_ABOVE;
              end
            end
            TAP_ABOVE: begin
              if (limitHit) begin
                state_reg <= TAP_WAIT_LOW;
              end else if (sampleValid && !above) begin
                state_reg <= TAP_IDLE;
              end
            end
            TAP_WAIT_LOW: begin
              if (sampleValid && !above) begin
                state_reg <= TAP_IDLE;
              end
            end
            default: state_reg <= TAP_IDLE;
          endcase
        end
      end

      // Saturates at 255 so a stalled fall can never wrap back under the limit
      always_ff @(posedge clk) begin
        if (reset || state_reg != TAP_ABOVE) begin
          count_reg <= 8'h00;
        end else if (stepBus[axis].stepPulse && count_reg != 8'hff) begin
          count_reg <= count_reg + 8'h01;
        end
      end

      always_ff @(posedge clk) begin
        if (reset) begin
          valid_reg    <= 1'b0;
          expired_reg  <= 1'b0;
          negative_reg <= 1'b0;
        end else begin
          valid_reg   <= state_reg == TAP_ABOVE && !limitHit && sampleValid && !above;
          expired_reg <= state_reg == TAP_ABOVE && limitHit;
          if (state_reg == TAP_IDLE && sampleValid && above) begin
            negative_reg <= accel[axis][11];
          end
        end
      end

      assign tapValid[axis]    = valid_reg;
      assign tapExpired[axis]  = expired_reg;
      assign tapNegative[axis] = negative_reg;

      startAbove_a: assert property (
        state_reg == TAP_IDLE && sampleValid
          && magnitude >= ((12'({5'b0, threshold[axis]}) + 12'd1) << `THRESHOLD_LSB_SHIFT)
        |=> state_reg == TAP_ABOVE)
        else $error("candidate did not start above threshold");

      validInTime_a: assert property (
        valid_reg |-> $past(state_reg) == TAP_ABOVE
          && $past(count_reg) < $past(timeLimitField_reg) && $past(sampleValid))
        else $error("tap accepted outside the time limit");

      expireCancel_a: assert property (
        state_reg == TAP_ABOVE && count_reg >= timeLimitField_reg
        |=> state_reg == TAP_WAIT_LOW && expired_reg && !valid_reg ##1 count_reg == 8'h00)
        else $error("expired candidate was not cancelled");

      stepCount_a: assert property (
        state_reg == TAP_ABOVE && stepBus[axis].stepPulse && count_reg < timeLimitField_reg
        |=> count_reg == $past(count_reg) + 8'h01)
        else $error("time step not counted");

      tapValid_c: cover property (state_reg == TAP_ABOVE ##[1:50] valid_reg);
      tapExpired_c: cover property (expired_reg && timeLimitField_reg > 8'h01);
    end
  endgenerate

  thrYRead_a: assert property (
    regRead && regAddr == `ADDR_TAP_THRESHOLD_Y
    |=> regRdData == {1'b0, $past(yThresholdField_reg)})
    else $error("Y threshold read mismatch");

  thrZRead_a: assert property (
    regRead && regAddr == `ADDR_TAP_THRESHOLD_Z
    |=> regRdData[7] == 1'b0 && regRdData[6:0] == $past(zThresholdField_reg))
    else $error("Z threshold read mismatch");

  limitWrite_a: assert property (
    regWrite && regAddr == `ADDR_TAP_TIME_LIMIT ##1 regRead && regAddr == `ADDR_TAP_TIME_LIMIT
    |=> regRdData == $past(regWrData, 2))
    else $error("time limit write not read back");

  resetValue_a: assert property (@(posedge clk) disable iff (1'b0)
    reset |=> yThresholdField_reg == 7'h00 && zThresholdField_reg == 7'h00
      && timeLimitField_reg == 8'h00 && tapValid == 2'b00)
    else $error("register reset value wrong");

  hiResStep_a: assert property (
    oversamplingMode == HIGH_RESOLUTION_OVERSAMPLING
    |-> exponent == (tapLowpassEnable ? ((outputDataRate == 3'h0) ? 4'h1 : 4'h2) : 4'h0))
    else $error("high-resolution step size wrong");
endmodule

// *** tap_host_model.sv ***
// Host side of the byte register port
`timescale 1ns/1ns
module tap_host_model (
  input  wire logic       clk,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrite,
  output logic            regRead,
  input  wire logic [7:0] regRdData
);
  initial begin
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWrite  = 1'b0;
    regRead   = 1'b0;
  end

  // One access per call, strobe held across exactly one rising edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge clk);
    regAddr   = a;
    regWrData = d;
    regWrite  = wr;
    regRead   = !wr;
    @(negedge clk);
    q         = regRdData;
    regWrite  = 1'b0;
    regRead   = 1'b0;
    // Released lines show the inverse so a stale value is never trusted
    regAddr   = ~a;
    regWrData = ~d;
  endtask

  // Write, then read the same address on the very next edge
  task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    regAddr   = a;
    regWrData = d;
    regWrite  = 1'b1;
    @(negedge clk);
    regWrite  = 1'b0;
    regRead   = 1'b1;
    @(negedge clk);
    q         = regRdData;
    regRead   = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
  endtask
endmodule

// *** test_pulse_threshold_time_limit.sv ***
// Self-checking bench for the tap threshold and time-limit block
`timescale 1ns/1ns
module test_pulse_threshold_time_limit;
  import tap_pulse_pkg::*;
  localparam int B = 4;
  localparam logic       LP [7] = '{1, 1, 1, 0, 0, 1, 0};
  localparam logic [1:0] MD [7] = '{0, 1, 2, 3, 0, 3, 1};
  localparam logic [2:0] RT [7] = '{0, 5, 7, 7, 3, 6, 4};
  localparam int         EX [7] = '{1, 7, 2, 6, 2, 8, 3};
  logic          clk;
  logic          reset;
  logic          sampleValid;
  logic          tapLowpassEnable;
  logic          regWrite;
  logic          regRead;
  logic [7:0]    regAddr;
  logic [7:0]    regWrData;
  logic [7:0]    regRdData;
  logic [7:0]    q;
  logic [11:0]   accelY;
  logic [11:0]   accelZ;
  data_rate_t    outputDataRate;
  oversampling_e oversamplingMode;
  logic [1:0]    tapValid;
  logic [1:0]    tapNegative;
  logic [1:0]    tapExpired;
  logic [1:0]    sawValid;
  int            n_errors;
  int            n_tests;
  int            t0;
  int            t1;
  int            t2;

  pulse_threshold_time_limit #(.BASE_STEP_CYCLES(B)) i_dut (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .sampleValid(sampleValid), .accelY(accelY), .accelZ(accelZ),
    .outputDataRate(outputDataRate), .oversamplingMode(oversamplingMode),
    .tapLowpassEnable(tapLowpassEnable), .tapValid(tapValid),
    .tapNegative(tapNegative), .tapExpired(tapExpired)
  );

  tap_host_model i_host (
    .clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) sawValid <= sawValid | tapValid;

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.access(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_host.access(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask

  task automatic sample(input logic [11:0] y, input logic [11:0] z);
    @(negedge clk);
    accelY      = y;
    accelZ      = z;
    sampleValid = 1'b1;
    @(negedge clk);
    sampleValid = 1'b0;
    accelY      = ~y;
    accelZ      = ~z;
  endtask

  task automatic wait_evt(input logic ex, output int c);
    c = 0;
    while ((ex ? tapExpired[0] : tapValid[0]) !== 1'b1) begin
      @(negedge clk);
      c++;
      if (c > 5000) begin
        $display("[ERR] t=%0t timeout kind %h after %h cycles", $time, ex, c);
        n_errors++;
        tally_and_finish();
      end
    end
  endtask

  // Cycles from an above-threshold Y sample to its expiry
  task automatic expire_time(input logic lp, input oversampling_e m, input data_rate_t r,
                             input logic [7:0] lim, output int c);
    tapLowpassEnable = lp;
    oversamplingMode = m;
    outputDataRate   = r;
    wr(8'h26, lim);
    sawValid = 2'b00;
    sample(12'h030, 12'h000);
    wait_evt(1'b1, c);
    sample(12'h000, 12'h000);
    repeat (2) @(negedge clk);
    chk(sawValid, 2'b00);
  endtask

  initial begin
    reset            = 1'b1;
    sampleValid      = 1'b0;
    accelY           = 12'h000;
    accelZ           = 12'h000;
    outputDataRate   = 3'h0;
    oversamplingMode = HIGH_RESOLUTION_OVERSAMPLING;
    tapLowpassEnable = 1'b0;
    sawValid         = 2'b00;
    n_errors         = 0;
    n_tests          = 0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    rd(8'h24, 8'h00);
    rd(8'h25, 8'h00);
    rd(8'h26, 8'h00);
    wr(8'h24, 8'hff);
    rd(8'h24, 8'h7f);
    wr(8'h25, 8'h80);
    rd(8'h25, 8'h00);
    wr(8'h26, 8'ha5);
    rd(8'h26, 8'ha5);
    i_host.write_read(8'h26, 8'h3c, q);
    chk(q, 8'h3c);
    wr(8'h27, 8'h5a);
    rd(8'h27, 8'h00);
    wr(8'h24, 8'h02);
    wr(8'h25, 8'h7f);
    wr(8'h26, 8'h10);
    // Magnitudes one count short of exceeding must not start a candidate
    sawValid = 2'b00;
    sample(12'h02f, 12'h801);
    sample(12'h000, 12'h000);
    repeat (2) @(negedge clk);
    chk(sawValid, 2'b00);
    sample(12'hfd0, 12'h800);
    @(negedge clk);
    chk(tapNegative, 2'b11);
    sample(12'h000, 12'h000);
    wait_evt(1'b0, t0);
    chk(tapValid, 2'b11);
    @(negedge clk);
    chk(tapValid, 2'b00);
    expire_time(1'b0, HIGH_RESOLUTION_OVERSAMPLING, 3'h0, 8'h01, t0);
    chk(tapNegative[0], 1'b0);
    expire_time(1'b0, HIGH_RESOLUTION_OVERSAMPLING, 3'h0, 8'hff, t1);
    chk(t1 - t0, 254 * B);
    expire_time(1'b0, HIGH_RESOLUTION_OVERSAMPLING, 3'h0, 8'h00, t1);
    chk(t1, 1);
    sample(12'h000, 12'h800);
    @(negedge clk);
    chk(tapExpired, 2'b10);
    chk(tapNegative, 2'b10);
    sample(12'h000, 12'h000);
    expire_time(1'b0, HIGH_RESOLUTION_OVERSAMPLING, 3'h3, 8'h02, t2);
    for (int i = 0; i < 7; i++) begin
      expire_time(LP[i], oversampling_e'(MD[i]), RT[i], 8'h02, t1);
      chk(t1 - t2, 2 * B * ((1 << EX[i]) - 1));
    end
    tally_and_finish();
  end
endmodule
